// file: common/psram_host_pkg.sv
// Purpose: constants, register map and state type of the pseudo-static RAM host controller
// Assumes: pclk runs at 10 MHz
// Notes: times are kept in ns, cycle counts are derived from them
//
// Functional notes
// - async read holds select, output drive and byte selects low, write strobe high.
// - async write needs select, write strobe, byte selects low; output drive ignored.
// - without page mode, address latch pulses for capture or stays low throughout.
// - clock stays low in async operation; hold_off_flag is ignored there.
// - write strobe low time never exceeds max_select_low_time.
// - page reads need refresh_config_reg bit 7, latch low and clock low.
// - select rises after a page access and never stays low past max_select_low_time.
// - burst address and direction are taken at first clock rise with latch low.
// - after power-up the device needs 150us with select held high.
// - deep_sleep begins at select rise after refresh_config_reg bit 4 written zero.
// - burst configuration access keeps select low for a single-word burst.
// - burst suspend holds the clock static; output drive high floats data.
package psram_host_pkg;

  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_ADDR = 8'h04;
  localparam logic [7:0] OFF_WDATA = 8'h08;
  localparam logic [7:0] OFF_RDATA = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_PAGE = 8'h40;
  localparam logic [7:0] OFF_PAGE_END = 8'h7C;

  localparam int CTRL_START = 0;
  localparam int CTRL_WRITE = 1;
  localparam int CTRL_PAGE = 2;
  localparam int CTRL_CFG = 3;
  localparam int CTRL_ADVP = 4;
  localparam int CTRL_SYNC = 5;
  localparam int CTRL_WPOL = 6;
  localparam int CTRL_LBE = 8;
  localparam int CTRL_HBE = 9;
  localparam int CTRL_PCNT = 12;
  localparam logic [31:0] CTRL_RST = 32'h0000_0300;

  localparam int STAT_BUSY = 0;
  localparam int STAT_INIT = 1;
  localparam int STAT_DONE = 2;
  localparam int STAT_ABORT = 3;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_NS = 100;
  localparam int INIT_NS = 150000;
  localparam int ACC_NS = 70;
  localparam int PAGE_NS = 20;
  localparam int WR_NS = 70;
  localparam int MAX_SELECT_LOW_TIME_NS = 4000;
  localparam int SYNC_CYC = 4;
  localparam logic [11:0] INIT_CYC = 12'((INIT_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [11:0] A_DONE = 12'((ACC_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC);
  localparam logic [11:0] P_DONE = 12'((PAGE_NS + CLK_NS - 1) / CLK_NS + SYNC_CYC);
  localparam logic [11:0] W_DONE = 12'((WR_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [11:0] MAX_SELECT_LOW_TIME_CYC = 12'(MAX_SELECT_LOW_TIME_NS / CLK_NS);
  localparam logic [11:0] MAX_SELECT_LOW_TIME_ABORT = 12'(MAX_SELECT_LOW_TIME_NS / CLK_NS - 2);
  localparam logic [11:0] B_SYNC = 12'(SYNC_CYC);
  localparam logic [11:0] BURST_LAT = 12'h003;

  typedef enum logic [3:0] {
    ST_INIT, ST_IDLE, ST_A_ACC, ST_PG_ACC, ST_W_HOLD, ST_W_REL,
    ST_B_LO, ST_B_HI, ST_B_X, ST_B_CAP, ST_END
  } state_t;

endpackage

// file: design/psram_host.sv
// Purpose: APB-programmed host that drives a pseudo-static RAM bus in async, page and burst modes
// Assumes: pins of the memory are sampled through three-flop filters
// Notes: one operation at a time; a start while busy launches nothing, but its control word still overwrites ctrl_q
//
// The implementer's own choices: the address map and the APB slave port.
`timescale 1ns/1ps
module psram_host
  import psram_host_pkg::*;
#(
  parameter int ADDR_W = 21
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [ADDR_W-1:0] mem_addr,
  output logic [15:0] dq_out,
  output logic dq_oe,
  input wire logic [15:0] dq_in,
  output logic mem_clk,
  output logic addr_latch_n,
  output logic chip_select_n,
  output logic output_drive_n,
  output logic write_strobe_n,
  output logic low_byte_sel_n,
  output logic high_byte_sel_n,
  output logic cfg_space_sel,
  input wire logic hold_off_flag
);

  if (ADDR_W < 5 || ADDR_W > 32) begin : g_chk
    $error("ADDR_W must lie between 5 and 32");
  end

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  state_t state_q;
  logic [11:0] cnt_q, cs_low_q;
  logic [3:0] idx_q;
  logic [31:0] ctrl_q, prdata_q, rd_d;
  logic [ADDR_W-1:0] addr_q, mem_addr_q;
  logic [15:0] wdata_q, rdata_q, dq_out_q;
  logic [15:0] dq_s1_q, dq_s2_q, dq_s3_q, dq_f_q;
  logic [15:0] page_mem_q [16];
  logic [2:0] wt_s_q;
  logic wt_f_q, pready_q, pslverr_q, done_q, abort_q, init_done_q;
  logic dq_oe_q, mem_clk_q, addr_latch_n_q, chip_select_n_q, output_drive_n_q;
  logic write_strobe_n_q, low_byte_sel_n_q, high_byte_sel_n_q, cfg_space_sel_q;
  logic apb_setup, apb_wr, start, cap_now, max_select_low_time_hit, wait_act, is_wr, active;

  function automatic logic is_page(input logic [7:0] a);
    return a >= OFF_PAGE && a <= OFF_PAGE_END && a[1:0] == 2'b00;
  endfunction

  assign apb_setup = psel && !penable && !pready_q;
  assign apb_wr = psel && penable && pready_q && pwrite;
  assign start = apb_wr && paddr == OFF_CTRL && pwdata[CTRL_START] && state_q == ST_IDLE;
  assign is_wr = ctrl_q[CTRL_WRITE];
  assign wait_act = wt_f_q == ctrl_q[CTRL_WPOL];
  assign max_select_low_time_hit = !chip_select_n_q && cs_low_q >= MAX_SELECT_LOW_TIME_ABORT;
  assign active = state_q != ST_INIT && state_q != ST_IDLE && state_q != ST_END;
  assign cap_now = (state_q == ST_A_ACC && cnt_q == A_DONE) || (state_q == ST_PG_ACC && cnt_q == P_DONE)
    || (state_q == ST_B_CAP && !is_wr && cnt_q == B_SYNC);

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  always_comb
  begin
    rd_d = 32'h0000_0000;
    if (paddr == OFF_CTRL)
      rd_d = ctrl_q;
    else if (paddr == OFF_ADDR)
      rd_d = 32'(addr_q);
    else if (paddr == OFF_WDATA)
      rd_d = {16'h0000, wdata_q};
    else if (paddr == OFF_RDATA)
      rd_d = {16'h0000, rdata_q};
    else if (paddr == OFF_STATUS)
      rd_d = {28'h0000000, abort_q, done_q, init_done_q, state_q != ST_IDLE};
    else if (is_page(paddr))
      rd_d = {16'h0000, page_mem_q[paddr[5:2]]};
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end
    else if (clk_en)
    begin
      pready_q <= apb_setup;
      if (apb_setup)
      begin
        pslverr_q <= !(paddr == OFF_CTRL || paddr == OFF_ADDR || paddr == OFF_WDATA
          || paddr == OFF_RDATA || paddr == OFF_STATUS || is_page(paddr));
        prdata_q <= rd_d;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= CTRL_RST;
      addr_q <= '0;
      wdata_q <= 16'h0000;
    end
    else if (clk_en && apb_wr)
    begin
      if (paddr == OFF_CTRL)
        ctrl_q <= {pwdata[31:1], 1'b0};
      else if (paddr == OFF_ADDR)
        addr_q <= pwdata[ADDR_W-1:0];
      else if (paddr == OFF_WDATA)
        wdata_q <= pwdata[15:0];
    end
  end

  // sticky flags: a hardware set in the clearing cycle survives
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      done_q <= 1'b0;
      abort_q <= 1'b0;
    end
    else if (clk_en)
    begin
      done_q <= (done_q && !(apb_wr && paddr == OFF_STATUS && pwdata[STAT_DONE])) || state_q == ST_END;
      abort_q <= (abort_q && !(apb_wr && paddr == OFF_STATUS && pwdata[STAT_ABORT])) || (max_select_low_time_hit && active);
    end
  end

  // ----------------------------------------------------------------
  // pin input filters
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dq_s1_q <= 16'h0000;
      dq_s2_q <= 16'h0000;
      dq_s3_q <= 16'h0000;
      dq_f_q <= 16'h0000;
      wt_s_q <= 3'h0;
      wt_f_q <= 1'b0;
    end
    else if (clk_en)
    begin
      dq_s1_q <= dq_in;
      dq_s2_q <= dq_s1_q;
      dq_s3_q <= dq_s2_q;
      dq_f_q <= (dq_s2_q & dq_s3_q) | (dq_f_q & (dq_s2_q | dq_s3_q));
      wt_s_q <= {wt_s_q[1:0], hold_off_flag};
      wt_f_q <= (wt_s_q[1] & wt_s_q[2]) | (wt_f_q & (wt_s_q[1] | wt_s_q[2]));
    end
  end

  // ----------------------------------------------------------------
  // read capture
  // ----------------------------------------------------------------
  always_ff @(posedge pclk)
  begin
    if (clk_en && cap_now)
      page_mem_q[idx_q] <= dq_f_q;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      rdata_q <= 16'h0000;
    else if (clk_en && cap_now)
      rdata_q <= dq_f_q;
  end

  // select low time is counted so no access outlives the refresh window
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cs_low_q <= 12'h000;
    else if (clk_en)
      cs_low_q <= chip_select_n_q ? 12'h000 : cs_low_q + 12'h001;
  end

  // ----------------------------------------------------------------
  // bus sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= ST_INIT;
      cnt_q <= 12'h000;
      idx_q <= 4'h0;
      init_done_q <= 1'b0;
      mem_addr_q <= '0;
      dq_out_q <= 16'h0000;
      dq_oe_q <= 1'b0;
      mem_clk_q <= 1'b0;
      addr_latch_n_q <= 1'b1;
      chip_select_n_q <= 1'b1;
      output_drive_n_q <= 1'b1;
      write_strobe_n_q <= 1'b1;
      low_byte_sel_n_q <= 1'b1;
      high_byte_sel_n_q <= 1'b1;
      cfg_space_sel_q <= 1'b0;
    end
    else if (clk_en)
    begin
      case (state_q)
        ST_INIT:
        begin
          cnt_q <= cnt_q + 12'h001;
          if (cnt_q == INIT_CYC - 12'h001)
          begin
            init_done_q <= 1'b1;
            state_q <= ST_IDLE;
          end
        end
        ST_IDLE:
        begin
          // the command word lands in ctrl_q at this very edge, so it is decoded from pwdata
          if (start)
          begin
            mem_addr_q <= addr_q;
            cfg_space_sel_q <= pwdata[CTRL_CFG];
            chip_select_n_q <= 1'b0;
            addr_latch_n_q <= 1'b0;
            low_byte_sel_n_q <= !pwdata[CTRL_LBE];
            high_byte_sel_n_q <= !pwdata[CTRL_HBE];
            dq_out_q <= wdata_q;
            cnt_q <= 12'h000;
            idx_q <= 4'h0;
            // configuration writes carry their value on the address lines
            dq_oe_q <= pwdata[CTRL_WRITE] && !pwdata[CTRL_CFG];
            write_strobe_n_q <= !pwdata[CTRL_WRITE];
            output_drive_n_q <= pwdata[CTRL_WRITE];
            if (pwdata[CTRL_SYNC] && !pwdata[CTRL_PAGE])
            begin
              output_drive_n_q <= 1'b1;
              state_q <= ST_B_LO;
            end
            else if (pwdata[CTRL_WRITE])
              state_q <= ST_W_HOLD;
            else
              state_q <= pwdata[CTRL_PAGE] ? ST_PG_ACC : ST_A_ACC;
          end
        end
        ST_A_ACC, ST_PG_ACC:
        begin
          if (ctrl_q[CTRL_ADVP] && !ctrl_q[CTRL_PAGE])
            addr_latch_n_q <= 1'b1;
          cnt_q <= cnt_q + 12'h001;
          if (cap_now)
          begin
            if (ctrl_q[CTRL_PAGE] && idx_q != ctrl_q[CTRL_PCNT+:4])
            begin
              idx_q <= idx_q + 4'h1;
              mem_addr_q[3:0] <= mem_addr_q[3:0] + 4'h1;
              cnt_q <= 12'h000;
              state_q <= ST_PG_ACC;
            end
            else
              state_q <= ST_END;
          end
        end
        ST_W_HOLD:
        begin
          if (ctrl_q[CTRL_ADVP])
            addr_latch_n_q <= 1'b1;
          cnt_q <= cnt_q + 12'h001;
          if (cnt_q >= W_DONE - 12'h001)
          begin
            write_strobe_n_q <= 1'b1;
            state_q <= ST_W_REL;
          end
        end
        ST_W_REL:
          state_q <= ST_END;
        ST_B_LO:
        begin
          mem_clk_q <= 1'b1;
          state_q <= ST_B_HI;
        end
        ST_B_HI:
        begin
          mem_clk_q <= 1'b0;
          addr_latch_n_q <= 1'b1;
          write_strobe_n_q <= 1'b1;
          output_drive_n_q <= is_wr;
          cnt_q <= cnt_q + 12'h001;
          // the filtered flag lags the pin, so a minimum latency is always spent
          if (cnt_q >= BURST_LAT && !wait_act)
            state_q <= ST_B_X;
          else
            state_q <= ST_B_LO;
        end
        ST_B_X:
        begin
          mem_clk_q <= 1'b1;
          cnt_q <= 12'h000;
          state_q <= ST_B_CAP;
        end
        ST_B_CAP:
        begin
          cnt_q <= cnt_q + 12'h001;
          if (is_wr || cnt_q == B_SYNC)
            state_q <= ST_END;
        end
        ST_END:
        begin
          chip_select_n_q <= 1'b1;
          output_drive_n_q <= 1'b1;
          write_strobe_n_q <= 1'b1;
          addr_latch_n_q <= 1'b1;
          low_byte_sel_n_q <= 1'b1;
          high_byte_sel_n_q <= 1'b1;
          cfg_space_sel_q <= 1'b0;
          dq_oe_q <= 1'b0;
          mem_clk_q <= 1'b0;
          state_q <= ST_IDLE;
        end
        default:
          state_q <= ST_IDLE;
      endcase
      if (max_select_low_time_hit && active)
        state_q <= ST_END;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign mem_addr = mem_addr_q;
  assign dq_out = dq_out_q;
  assign dq_oe = dq_oe_q;
  assign mem_clk = mem_clk_q;
  assign addr_latch_n = addr_latch_n_q;
  assign chip_select_n = chip_select_n_q;
  assign output_drive_n = output_drive_n_q;
  assign write_strobe_n = write_strobe_n_q;
  assign low_byte_sel_n = low_byte_sel_n_q;
  assign high_byte_sel_n = high_byte_sel_n_q;
  assign cfg_space_sel = cfg_space_sel_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_addr_cap;
    $rose(mem_clk_q) && !addr_latch_n_q && !chip_select_n_q;
  endsequence
  sequence s_wr_release;
    write_strobe_n_q && !chip_select_n_q ##1 chip_select_n_q;
  endsequence

  a_init_cs_high: assert property (state_q == ST_INIT |-> chip_select_n_q)
    else $error("select low during power-up wait");
  a_async_clk_low: assert property (state_q inside {ST_A_ACC, ST_PG_ACC, ST_W_HOLD} |-> !mem_clk_q)
    else $error("clock not low in async access");
  a_read_strobes: assert property (state_q == ST_A_ACC |-> !chip_select_n_q && !output_drive_n_q
    && write_strobe_n_q)
    else $error("async read strobes wrong");
  a_write_strobes: assert property (!write_strobe_n_q && state_q == ST_W_HOLD |-> !chip_select_n_q
    && output_drive_n_q)
    else $error("async write strobes wrong");
  a_write_release: assert property (clk_en && state_q == ST_W_REL && !max_select_low_time_hit ##1 clk_en |-> s_wr_release)
    else $error("write not released before select");
  a_page_latch_low: assert property (state_q == ST_PG_ACC |-> !addr_latch_n_q && !mem_clk_q)
    else $error("page read without latch and clock low");
  a_select_bound: assert property (!chip_select_n_q |-> cs_low_q < MAX_SELECT_LOW_TIME_CYC)
    else $error("select held low too long");
  a_burst_addr: assert property (clk_en && state_q == ST_B_LO && cnt_q == 12'h000 |=> s_addr_cap)
    else $error("burst address not taken with latch low");
  a_end_release: assert property (clk_en && state_q == ST_END |=> chip_select_n_q && !dq_oe_q)
    else $error("select not raised at end");
  a_apb_ready: assert property (clk_en && apb_setup |=> pready_q)
    else $error("apb answer missing");

endmodule // psram_host

// file: testbench/psram_dev_model.sv
// Purpose: behavioural pseudo-static RAM at the far side of the host
// Assumes: bench addresses stay below 1024 words
// Notes: undriven pins show the inverse of their last value, never a held value
`timescale 1ns/1ps
module psram_dev_model #(
  parameter logic [15:0] ID_VAL = 16'h5A3C, // arbitrary value
  parameter logic [15:0] BCR_DEF = 16'h8000
)(
  input wire logic [20:0] mem_addr,
  input wire logic [15:0] dq_w,
  output logic [15:0] dq_drv,
  input wire logic mem_clk,
  input wire logic addr_latch_n,
  input wire logic chip_select_n,
  input wire logic output_drive_n,
  input wire logic write_strobe_n,
  input wire logic low_byte_sel_n,
  input wire logic high_byte_sel_n,
  input wire logic cfg_space_sel,
  output logic hold_off_flag
);
  logic [15:0] mem [0:1023];
  logic [15:0] bcr_q = BCR_DEF;
  logic [15:0] rcr_q = 16'h0010;
  logic [15:0] wd, rv;
  logic [20:0] wa, ba;
  logic wl, wh, wc, armed, brst, bwr, deep_q, zq;
  int rises, addr_moves;
  initial
  begin
    addr_moves = 0;
    armed = 0; brst = 0; bwr = 0; deep_q = 0; zq = 0; dq_drv = 16'h0000; rises = 0;
    for (int i = 0; i < 1024; i++) mem[i] = 16'h0000;
  end
  // floating pins wander so a stale value can never pass for data
  always #37 zq = ~zq;
  // --------------------------------------------------------------
  // async write: snapshot while active, commit on first release
  // --------------------------------------------------------------
  always @*
    if (!chip_select_n && !write_strobe_n && (cfg_space_sel || !(low_byte_sel_n && high_byte_sel_n))
        && !mem_clk && !brst)
    begin
      armed = 1; wa = mem_addr; wd = dq_w; wc = cfg_space_sel;
      wl = !low_byte_sel_n; wh = !high_byte_sel_n;
    end
  always @(posedge chip_select_n or posedge write_strobe_n or posedge low_byte_sel_n or posedge high_byte_sel_n)
  begin
    if (armed && wc)
    begin
      if (wa[19:18] == 2'b10) bcr_q = wa[15:0];
      else rcr_q = wa[15:0];
    end
    else if (armed)
      mem[wa[9:0]] = {wh ? wd[15:8] : mem[wa[9:0]][15:8], wl ? wd[7:0] : mem[wa[9:0]][7:0]};
    armed = 0;
    if (chip_select_n && !rcr_q[4]) deep_q = 1;
    if (chip_select_n) brst = 0;
  end
  always @(negedge chip_select_n) deep_q = 0;
  // address motion while selected keeps the array in active power
  always @(mem_addr)
    if (!chip_select_n) addr_moves++;
  // --------------------------------------------------------------
  // burst: address and direction at first clock rise with latch low
  // --------------------------------------------------------------
  always @(posedge mem_clk)
    if (!chip_select_n && !addr_latch_n && !brst)
    begin
      brst = 1; armed = 0; ba = mem_addr; bwr = !write_strobe_n; rises = 0;
    end
    else if (brst)
    begin
      rises++;
      if (bwr && rises > 3) mem[ba[9:0]] = dq_w;
    end
  assign rv = cfg_space_sel ? (mem_addr[19:18] == 2'b01 ? ID_VAL : mem_addr[19:18] == 2'b10 ? bcr_q : rcr_q)
                            : mem[brst ? ba[9:0] : mem_addr[9:0]];
  always @(chip_select_n, output_drive_n, write_strobe_n, rv, rises, brst)
    if (!chip_select_n && !output_drive_n && (brst ? !bwr && rises > 3 : write_strobe_n))
      dq_drv <= #70 rv;
    else
      dq_drv <= #1 ~dq_drv;
  assign hold_off_flag = chip_select_n ? zq : (brst && rises >= 3) ? !bcr_q[10] : bcr_q[10];
endmodule // psram_dev_model

// file: testbench/psram_host_tb.sv
// Purpose: self-checking bench for the APB pseudo-static RAM host
// Assumes: device model answers within its access time
// Notes: addresses stay below 1024 words so the model array covers them
`timescale 1ns/1ps
module psram_host_tb;
  import psram_host_pkg::*;
  localparam logic [15:0] ID_VAL = 16'h5A3C; // arbitrary value
  logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, perr, sync_on;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [20:0] mem_addr, a;
  logic [15:0] dq_out, dq_drv, dq_w, d;
  logic [15:0] shadow [0:1023];
  logic dq_oe, mem_clk, addr_latch_n, chip_select_n, output_drive_n, write_strobe_n;
  logic low_byte_sel_n, high_byte_sel_n, cfg_space_sel, hold_off_flag;
  int err_total, check_count;
  assign dq_w = dq_oe ? dq_out : dq_drv;
  psram_host #(.ADDR_W(21)) DUT (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mem_addr(mem_addr), .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_w), .mem_clk(mem_clk),
    .addr_latch_n(addr_latch_n), .chip_select_n(chip_select_n), .output_drive_n(output_drive_n),
    .write_strobe_n(write_strobe_n), .low_byte_sel_n(low_byte_sel_n), .high_byte_sel_n(high_byte_sel_n),
    .cfg_space_sel(cfg_space_sel), .hold_off_flag(hold_off_flag));
  psram_dev_model #(.ID_VAL(ID_VAL), .BCR_DEF(16'h8000)) u_dev (.mem_addr(mem_addr), .dq_w(dq_w),
    .dq_drv(dq_drv), .mem_clk(mem_clk), .addr_latch_n(addr_latch_n), .chip_select_n(chip_select_n),
    .output_drive_n(output_drive_n), .write_strobe_n(write_strobe_n), .low_byte_sel_n(low_byte_sel_n),
    .high_byte_sel_n(high_byte_sel_n), .cfg_space_sel(cfg_space_sel), .hold_off_flag(hold_off_flag));
  initial
  begin
    pclk = 0;
    forever #50 pclk = ~pclk;
  end
  // --------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------
  task automatic give_verdict;
    if (err_total == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic got, input logic exp);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %0t level %b expected %b", $time, got, exp);
    end
  endtask
  function automatic logic [15:0] merge(input logic [15:0] o, input logic [15:0] n, input logic [1:0] be);
    return {be[1] ? n[15:8] : o[15:8], be[0] ? n[7:0] : o[7:0]};
  endfunction
  // waits an edge first so a release and the next setup never share a time step
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= ad; pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic op(input logic [31:0] ctrl, input logic [20:0] ma, input logic [15:0] wd);
    apb(1'b1, OFF_ADDR, 32'(ma));
    apb(1'b1, OFF_WDATA, 32'(wd));
    apb(1'b1, OFF_CTRL, ctrl | 32'h1);
    do apb(1'b0, OFF_STATUS, 32'h0); while (rd[STAT_BUSY] !== 1'b0);
    apb(1'b0, OFF_STATUS, 32'h0);
    chk(rd & 32'hC, 32'h4);
    apb(1'b1, OFF_STATUS, 32'hC);
    apb(1'b0, OFF_RDATA, 32'h0);
  endtask
  task automatic cfg_wr(input logic [20:0] v);
    op(32'h30A, v, 16'h0000);
  endtask
  always @(posedge pclk)
    if (presetn && !sync_on && !chip_select_n && mem_clk)
    begin
      err_total++;
      $display("ERROR %0t clock high in async access", $time);
    end
  initial
  begin
    #3000000;
    err_total++;
    $display("ERROR %0t timeout", $time);
    give_verdict();
  end
  // --------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------
  initial
  begin
    presetn = 0; clk_en = 1; psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0; sync_on = 0;
    err_total = 0; check_count = 0;
    void'($urandom(32'hB117));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFF_CTRL, 32'h0); chk(rd, CTRL_RST);
    apb(1'b1, 8'h20, 32'h5); chk_pin(perr, 1'b1);
    apb(1'b0, 8'h20, 32'h0); chk(rd, 32'h0);
    apb(1'b1, OFF_CTRL, 32'h301);
    do
    begin
      apb(1'b0, OFF_STATUS, 32'h0);
      chk_pin(chip_select_n, 1'b1);
    end
    while (rd[STAT_INIT] !== 1'b1);
    // a setup offered while the clock enable is low must not be answered
    @(posedge pclk);
    clk_en <= 1'b0;
    psel <= 1'b1;
    paddr <= OFF_STATUS;
    repeat (4) @(posedge pclk);
    chk_pin(pready, 1'b0);
    psel <= 1'b0;
    clk_en <= 1'b1;
    op(32'h308, 21'h080000, 16'h0000); chk(rd, 32'h8000);
    op(32'h308, 21'h040000, 16'h0000); chk(rd, 32'(ID_VAL));
    for (int i = 0; i < 12; i++)
    begin
      a = 21'($urandom_range(1023)); d = 16'($urandom);
      op(32'h302 | ($urandom_range(1) << 4), a, d);
      shadow[a[9:0]] = d;
      op(32'h300 | ($urandom_range(1) << 4), a, 16'h0000); chk(rd, 32'(d));
    end
    for (int be = 1; be < 4; be++)
    begin
      d = 16'($urandom);
      op(32'h2 | (be << 8), a, d);
      shadow[a[9:0]] = merge(shadow[a[9:0]], d, be[1:0]);
      op(32'h300, a, 16'h0000); chk(rd, 32'(shadow[a[9:0]]));
    end
    cfg_wr(21'h000000); chk_pin(u_dev.deep_q, 1'b1);
    cfg_wr(21'h000090); chk_pin(u_dev.deep_q, 1'b0);
    a = 21'($urandom_range(63) << 4);
    for (int i = 0; i < 4; i++)
    begin
      d = 16'($urandom);
      op(32'h302, a + 21'(i), d);
      shadow[a[9:0] + 10'(i)] = d;
    end
    op(32'h3304, a, 16'h0000); chk(rd, 32'(shadow[a[9:0] + 10'd3]));
    chk_pin(u_dev.addr_moves >= 3, 1'b1);
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b0, OFF_PAGE + 8'(4 * i), 32'h0); chk(rd, 32'(shadow[a[9:0] + 10'(i)]));
    end
    for (int p = 0; p < 2; p++)
    begin
      cfg_wr(21'h080000 | 21'(p << 10));
      sync_on = 1;
      a = 21'($urandom_range(1023)); d = 16'($urandom);
      op(32'h322 | (p << 6), a, d);
      op(32'h320 | (p << 6), a, 16'h0000); chk(rd, 32'(d));
      sync_on = 0;
      cfg_wr(21'h088000);
      op(32'h300, a, 16'h0000); chk(rd, 32'(d));
    end
    give_verdict();
  end
endmodule // psram_host_tb
